// >>> rtl/eeprom_slave_pkg.sv
/*
 * Shared constants for the two-wire EEPROM slave front end: register map,
 * reset values, slave address layout, bus response codes and timing.
 * Assumes a 100 MHz core clock and 32-bit AXI4-Lite register access.
 */
package eeprom_slave_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
	localparam logic [7:0]  READ_DATA_OFFSET = 8'h08;
	localparam logic [7:0]  POINTER_OFFSET   = 8'h0c;
	localparam logic [7:0]  LAST_BYTE_OFFSET = 8'h10;

	localparam int          CTRL_ENABLE_BIT  = 0;
	localparam int          STAT_STANDBY_BIT = 0;
	localparam int          STAT_BUSY_BIT    = 1;
	localparam int          STAT_PROTECT_BIT = 2;
	localparam int          STAT_ACTIVE_BIT  = 3;
	localparam int          LAST_COUNT_POS   = 8;

	localparam logic        CTRL_ENABLE_RST  = 1'b1;
	localparam logic [7:0]  READ_DATA_RST    = 8'h00;
	localparam logic [15:0] POINTER_RST      = 16'h0000;
	// Bus lines rest high, straps and protect low
	localparam logic [5:0]  PINS_RST         = 6'h03;

	// ----------------------------------------------------------------
	// Slave address byte
	// ----------------------------------------------------------------
	localparam logic [3:0]  DEVICE_TYPE      = 4'ha;
	localparam logic        DIR_READ         = 1'b1;
	localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
	localparam logic [7:0]  PAGE_BYTES       = 8'h80;
	localparam int          PAGE_BITS        = 7;
	localparam int          ADDR_BITS        = 16;

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_FREQ_MHZ     = 100;
	localparam int          WRITE_TIME_US    = 5000;
	localparam int          WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;
	localparam int          BUSY_CNT_BITS    = 24;

endpackage

// >>> rtl/eeprom_slave_front.sv
/*
 * Two-wire bus slave front end of a 64K x 8 serial EEPROM with an
 * AXI4-Lite register port. Detects Start and Stop, shifts bytes, matches
 * the slave address, acknowledges, tracks the byte pointer and models the
 * internal programming cycle as a busy interval.
 * Assumes an external pull-up on the data line, pull-downs on the select
 * and protect pins, and a master that keeps its own side of the protocol.
 */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// Behaviour
// (R1) Data line stable while clock is high
// (R2) Data edge under high clock is condition
// (R3) One clock pulse per bit, sampled high
// (R4) Start: data falls while clock high
// (R5) Ignore bus and drive nothing before Start
// (R6) Stop: data rises while clock high
// (R7) Master ends every operation with Stop
// (R8) Master starts only on idle bus
// (R9) Receiver acknowledges each byte by pulling low
// (R10) Start anywhere restarts address reception
// (R11) Master recovers with nine clocks, then Start
// (R12) Standby after power-up until command
// (R13) Stop after non-write returns to standby
// (R14) After write, standby once programming ends
// (R15) Address top nibble must be 1010
// (R16) Next three bits match select pins
// (R17) Address bit zero: 1 read, 0 write
// (R18) Matching address acknowledged on ninth clock
// (R19) Floating select pin counts as zero
// (R20) Protect input high makes array read-only
// (R21) Byte pointer is sixteen bits wide
// (R22) Page writes up to 128 bytes
// (R23) No response during programming cycle
// (R24) Mismatch: release data, wait for Start
`timescale 1ns/10ps

module eeprom_slave_front
	import eeprom_slave_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        select_pin_low,
	input  wire logic        select_pin_mid,
	input  wire logic        select_pin_high,
	input  wire logic        write_protect,
	output logic             standby,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR_HI,
		ST_PTR_LO,
		ST_WDATA,
		ST_DATA_ACK,
		ST_RDATA,
		ST_MASTER_ACK,
		ST_WAIT
	} bus_state_e;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0]  pins_s1;
	logic [5:0]  pins_s2;
	logic        scl_d;
	logic        sda_d;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  select_s;
	logic        protect_s;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			// Idle level, so release shows no false clock edge
			pins_s1 <= PINS_RST;
			pins_s2 <= PINS_RST;
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
		end
		else
		begin
			pins_s1 <= {write_protect, select_pin_high, select_pin_mid,
				select_pin_low, sda_in, scl_in};
			pins_s2 <= pins_s1;
			scl_d   <= pins_s2[0];
			sda_d   <= pins_s2[1];
		end
	end

	assign scl_s     = pins_s2[0];
	assign sda_s     = pins_s2[1];
	// Pins read as driven; an open pin relies on the board pull-down
	assign select_s  = pins_s2[4:2]; // [R19]
	assign protect_s = pins_s2[5];

	// ----------------------------------------------------------------
	// Bus conditions
	// ----------------------------------------------------------------
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;

	assign scl_rise  = scl_s & ~scl_d; // [R3]
	assign scl_fall  = ~scl_s & scl_d;
	// Data edges under a high clock are conditions, never data [R2]
	assign start_det = scl_s & scl_d & sda_d & ~sda_s; // [R4]
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s; // [R6]

	// ----------------------------------------------------------------
	// Registers seen by software
	// ----------------------------------------------------------------
	logic        enable_reg;
	logic [7:0]  read_data_reg;
	logic [15:0] pointer_reg;
	logic [7:0]  last_byte_reg;
	logic [7:0]  page_count_reg;
	logic [BUSY_CNT_BITS-1:0] busy_cnt_reg;
	logic        busy;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	bus_state_e  state_reg;
	bus_state_e  after_ack_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  tx_reg;
	logic        is_write_reg;
	logic        addr_match;
	logic        sda_oe_reg;
	logic        standby_reg;

	assign busy       = busy_cnt_reg != '0;
	assign addr_match = (shift_reg[7:4] == DEVICE_TYPE) // [R15]
		&& (shift_reg[3:1] == select_s); // [R16]

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg     <= ST_IDLE;
			after_ack_reg <= ST_IDLE;
			bit_cnt_reg   <= 4'h0;
			shift_reg     <= 8'h00;
			tx_reg        <= 8'h00;
			is_write_reg  <= 1'b0;
			sda_oe_reg    <= 1'b0;
		end
		else if (!enable_reg)
		begin
			state_reg  <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end
		else if (start_det)
		begin
			// Restart wins over any byte in flight
			state_reg   <= ST_ADDR; // [R10]
			bit_cnt_reg <= 4'h0;
			sda_oe_reg  <= 1'b0;
		end
		else if (stop_det)
		begin
			state_reg  <= ST_IDLE; // [R13]
			sda_oe_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE, ST_WAIT:
				begin
					sda_oe_reg <= 1'b0; // [R5] [R24]
				end
				ST_ADDR, ST_PTR_HI, ST_PTR_LO, ST_WDATA:
				begin
					if (scl_rise && bit_cnt_reg != BITS_PER_BYTE)
					begin
						shift_reg   <= {shift_reg[6:0], sda_s};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE)
					begin
						bit_cnt_reg <= 4'h0;
						if (state_reg != ST_ADDR)
						begin
							sda_oe_reg    <= 1'b1; // [R9]
							state_reg     <= ST_DATA_ACK;
							after_ack_reg <= (state_reg == ST_PTR_HI) ? ST_PTR_LO
								: ST_WDATA;
						end
						else if (addr_match && !busy) // [R23]
						begin
							sda_oe_reg   <= 1'b1; // [R18]
							state_reg    <= ST_ADDR_ACK;
							is_write_reg <= shift_reg[0] != DIR_READ; // [R17]
						end
						else
						begin
							state_reg <= ST_WAIT; // [R24]
						end
					end
				end
				ST_ADDR_ACK, ST_DATA_ACK:
				begin
					if (scl_fall)
					begin
						if (state_reg == ST_ADDR_ACK && !is_write_reg)
						begin
							state_reg  <= ST_RDATA;
							tx_reg     <= {read_data_reg[6:0], 1'b0};
							sda_oe_reg <= ~read_data_reg[7];
						end
						else
						begin
							state_reg  <= (state_reg == ST_ADDR_ACK) ? ST_PTR_HI
								: after_ack_reg;
							sda_oe_reg <= 1'b0;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
					begin
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end
					else if (scl_fall)
					begin
						if (bit_cnt_reg == BITS_PER_BYTE)
						begin
							bit_cnt_reg <= 4'h0;
							sda_oe_reg  <= 1'b0;
							state_reg   <= ST_MASTER_ACK;
						end
						else
						begin
							// Changes only with the clock low [R1]
							sda_oe_reg <= ~tx_reg[7];
							tx_reg     <= {tx_reg[6:0], 1'b0};
						end
					end
				end
				ST_MASTER_ACK:
				begin
					if (scl_rise)
					begin
						state_reg <= sda_s ? ST_WAIT : ST_MASTER_ACK;
						tx_reg    <= read_data_reg;
					end
					else if (scl_fall)
					begin
						state_reg  <= ST_RDATA;
						sda_oe_reg <= ~tx_reg[7];
						tx_reg     <= {tx_reg[6:0], 1'b0};
					end
				end
				default:
				begin
					state_reg  <= ST_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Byte pointer, page count and programming cycle
	// ----------------------------------------------------------------
	logic        byte_done;
	logic        read_done;

	assign byte_done = scl_fall && bit_cnt_reg == BITS_PER_BYTE
		&& !start_det && !stop_det && enable_reg;
	assign read_done = scl_rise && state_reg == ST_MASTER_ACK
		&& !start_det && !stop_det && enable_reg;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pointer_reg    <= POINTER_RST;
			last_byte_reg  <= 8'h00;
			page_count_reg <= 8'h00;
		end
		else if (start_det)
		begin
			page_count_reg <= 8'h00;
		end
		else if (byte_done && state_reg == ST_PTR_HI)
		begin
			pointer_reg[15:8] <= shift_reg; // [R21]
		end
		else if (byte_done && state_reg == ST_PTR_LO)
		begin
			pointer_reg[7:0] <= shift_reg;
		end
		else if (byte_done && state_reg == ST_WDATA)
		begin
			last_byte_reg <= shift_reg;
			// Low page bits wrap; a long burst overwrites its page [R22]
			pointer_reg[PAGE_BITS-1:0] <= pointer_reg[PAGE_BITS-1:0] + 7'h01;
			if (page_count_reg != PAGE_BYTES)
			begin
				page_count_reg <= page_count_reg + 8'h01;
			end
		end
		else if (read_done || (byte_done && state_reg == ST_RDATA))
		begin
			if (byte_done)
			begin
				pointer_reg <= pointer_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_cnt_reg <= '0;
		end
		else if (busy)
		begin
			busy_cnt_reg <= busy_cnt_reg - BUSY_CNT_BITS'(1);
		end
		else if (stop_det && enable_reg && state_reg == ST_WDATA
			&& page_count_reg != 8'h00 && !protect_s) // [R20]
		begin
			busy_cnt_reg <= BUSY_CNT_BITS'(WRITE_CYCLES); // [R14]
		end
	end

	// Standby only with the bus idle and no programming pending
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			standby_reg <= 1'b1; // [R12]
		end
		else
		begin
			standby_reg <= state_reg == ST_IDLE && !busy; // [R13] [R14]
		end
	end

	assign sda_oe  = sda_oe_reg;
	assign standby = standby_reg;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_out <= 1'b0;
		end
		else
		begin
			// Open drain: only ever pulls low
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [7:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        do_write;

	assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg   <= 1'b1;
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg   <= 1'b1;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_reg == CTRL_OFFSET
					|| aw_addr_reg == READ_DATA_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enable_reg    <= CTRL_ENABLE_RST;
			read_data_reg <= READ_DATA_RST;
		end
		else if (do_write && w_strb_reg[0])
		begin
			if (aw_addr_reg == CTRL_OFFSET)
			begin
				enable_reg <= w_data_reg[CTRL_ENABLE_BIT];
			end
			if (aw_addr_reg == READ_DATA_OFFSET)
			begin
				read_data_reg <= w_data_reg[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic [31:0] read_mux;
	logic        read_hit;

	always_comb
	begin
		read_mux = 32'h0000_0000;
		read_hit = 1'b1;
		unique case (s_axi_araddr)
			CTRL_OFFSET:
			begin
				read_mux[CTRL_ENABLE_BIT] = enable_reg;
			end
			STATUS_OFFSET:
			begin
				read_mux[STAT_STANDBY_BIT] = standby_reg;
				read_mux[STAT_BUSY_BIT]    = busy;
				read_mux[STAT_PROTECT_BIT] = protect_s;
				read_mux[STAT_ACTIVE_BIT]  = state_reg != ST_IDLE;
			end
			READ_DATA_OFFSET:
			begin
				read_mux[7:0] = read_data_reg;
			end
			POINTER_OFFSET:
			begin
				read_mux[ADDR_BITS-1:0] = pointer_reg;
			end
			LAST_BYTE_OFFSET:
			begin
				read_mux[7:0] = last_byte_reg;
				read_mux[LAST_COUNT_POS +: 8] = page_count_reg;
			end
			default:
			begin
				read_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= read_mux;
			s_axi_rresp   <= read_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// >>> bench/eeprom_slave_front_props.sv
/*
 * Port-level checker for the EEPROM slave front end.
 * Assumes the bind at the foot of this file and one core clock domain.
 */
`timescale 1ns/10ps

module eeprom_slave_front_props
	import eeprom_slave_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic        scl_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        standby,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	property p_drain;
		sda_out == 1'b0;
	endproperty
	property p_quiet;
		standby |-> !sda_oe;
	endproperty
	// Drive may only move while the bus clock is low
	property p_oe_steady;
		scl_in && $past(scl_in) |-> $stable(sda_oe);
	endproperty
	property p_rd_answer;
		s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
			&& $stable(s_axi_rresp);
	endproperty
	property p_rd_close;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	property p_wr_answer;
		s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
	endproperty
	property p_wr_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_wr_close;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready;
	endproperty

	a_drain: assert property (p_drain) else $error("data pin value not low");
	a_quiet: assert property (p_quiet) else $error("drive while idle");
	a_oe_steady: assert property (p_oe_steady) else $error("drive moved, clock high");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_rd_hold: assert property (p_rd_hold) else $error("read answer unstable");
	a_rd_close: assert property (p_rd_close) else $error("read not closed");
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_wr_hold: assert property (p_wr_hold) else $error("write answer unstable");
	a_wr_close: assert property (p_wr_close) else $error("write not closed");
endmodule

bind eeprom_slave_front eeprom_slave_front_props #(.WRITE_CYCLES(WRITE_CYCLES))
	u_eeprom_slave_front_props (.core_clk, .nrst, .scl_in, .sda_out, .sda_oe, .standby,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// >>> bench/twowire_master_model.sv
/*
 * Behavioural two-wire bus master: clock, conditions and bytes.
 * Assumes the bench resolves the data line with a pull-up.
 */
`timescale 1ns/10ps

module twowire_master_model
(
	output logic      scl,
	output logic      pull,
	input  wire logic line
);
	// Clock stands high between frames
	initial
	begin
		scl = 1'b1;
		pull = 1'b0;
	end
	task automatic start();
		pull = 1'b0;
		#20 scl = 1'b1;
		#30 pull = 1'b1;
		#30 scl = 1'b0;
	endtask
	task automatic stop();
		#20 pull = 1'b1;
		#30 scl = 1'b1;
		#30 pull = 1'b0;
		#30;
	endtask
	// Clock out a stuck slave, then open a fresh frame
	task automatic recover();
		logic s;
		for (int i = 0; i < 9; i++)
		begin
			clk_bit(1'b1, s);
			if (s)
				break;
		end
		start();
	endtask
	// Long low phase leaves room for the slave's late drive
	task automatic clk_bit(input logic b, output logic s);
		#20 pull = !b;
		#30 scl = 1'b1;
		#30 s = line;
		scl = 1'b0;
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(last, s);
	endtask
endmodule

// >>> bench/serial_eeprom_bus_slave_front_bench.sv
/*
 * Self-checking bench for the EEPROM slave front end.
 * Assumes the two-wire master model and the bound checker.
 */
`timescale 1ns/10ps

module serial_eeprom_bus_slave_front_bench;
	import eeprom_slave_pkg::*;
	localparam int WCYC = 400;
	logic        core_clk, nrst, select_pin_low, select_pin_mid, select_pin_high;
	logic        write_protect, scl_in, pull, sda_out, sda_oe, standby;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, rnd, db, dt, hi;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, got_v;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  pins;
	logic        ack;
	int          mismatches, checked;
	logic [31:0] exp_q[$];
	string       name_q[$];
	event        got_e;
	wire logic   sda_in = !(pull || sda_oe);
	wire logic [3:0] s_axi_wstrb = 4'h1;

	eeprom_slave_front #(.WRITE_CYCLES(WCYC)) u_eeprom_slave_front (.core_clk, .nrst,
		.scl_in, .sda_in, .sda_out, .sda_oe, .select_pin_low, .select_pin_mid,
		.select_pin_high, .write_protect, .standby, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	twowire_master_model u_twowire_master_model (.scl(scl_in), .pull, .line(sda_in));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic report(input string n, input logic [31:0] e, input logic [31:0] g);
		name_q.push_back(n);
		exp_q.push_back(e);
		got_v = g;
		-> got_e;
		#1;
	endtask
	task automatic conclude();
		#20;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Register bus master
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw_open;
		logic w_open;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_open = 1'b1;
		w_open = 1'b1;
		// Each channel drops its valid at its own handshake
		do
		begin
			@(posedge core_clk);
			aw_open = aw_open && !s_axi_awready;
			w_open = w_open && !s_axi_wready;
			s_axi_awvalid <= aw_open;
			s_axi_wvalid <= w_open;
		end while (aw_open || w_open);
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// Bus transactions
	// ----------------------------------------------------------------
	task automatic probe(input logic [7:0] a, input logic e);
		logic k;
		// Pin moves stay clear of the sampling edge
		@(negedge core_clk);
		u_twowire_master_model.start();
		u_twowire_master_model.send_byte(a, k);
		u_twowire_master_model.stop();
		report("address ack", e, k);
	endtask
	task automatic wr_txn(input logic [7:0] h, input logic [7:0] l, input logic [7:0] v);
		logic [7:0] b[4];
		logic       k;
		b = '{{DEVICE_TYPE, pins, !DIR_READ}, h, l, v};
		@(negedge core_clk);
		u_twowire_master_model.start();
		for (int i = 0; i < 4; i++)
		begin
			u_twowire_master_model.send_byte(b[i], k);
			report("write ack", 1, k);
		end
		u_twowire_master_model.stop();
		repeat (10) @(posedge core_clk);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = !core_clk;
	end
	initial
	begin
		forever
		begin
			@(got_e);
			check_word(name_q.pop_front(), exp_q.pop_front(), got_v);
		end
	end
	initial
	begin
		#200000;
		mismatches++;
		conclude();
	end
	initial
	begin
		{nrst, select_pin_low, select_pin_mid, select_pin_high, write_protect} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		rnd = 8'h57;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (8) @(posedge core_clk);
		axi_rd(CTRL_OFFSET, d, r);
		report("ctrl", {31'h0, CTRL_ENABLE_RST}, d);
		axi_rd(STATUS_OFFSET, d, r);
		report("standby flag", 1, d[STAT_STANDBY_BIT]);
		axi_rd(8'h14, d, r);
		report("unmapped read", RESP_SLVERR, r);
		axi_wr(POINTER_OFFSET, 32'h0, r);
		report("read-only write", RESP_SLVERR, r);
		rnd = lfsr(rnd);
		dt = rnd;
		axi_wr(READ_DATA_OFFSET, {24'h0, dt}, r);
		report("data write", RESP_OKAY, r);
		// Passes 1 and 3 break one address field
		for (int i = 0; i < 6; i++)
		begin
			rnd = lfsr(rnd);
			pins = (i == 0) ? 3'h0 : rnd[2:0];
			{select_pin_high, select_pin_mid, select_pin_low} <= pins;
			repeat (4) @(posedge core_clk);
			probe({(i == 3) ? 4'h2 : DEVICE_TYPE, pins ^ ((i == 1) ? 3'h4 : 3'h0), 1'b0},
				i != 1 && i != 3);
		end
		@(negedge core_clk);
		u_twowire_master_model.start();
		u_twowire_master_model.send_byte({DEVICE_TYPE, pins, DIR_READ}, ack);
		u_twowire_master_model.recv_byte(1'b1, db);
		u_twowire_master_model.stop();
		report("read ack", 1, ack);
		report("read byte", dt, db);
		@(negedge core_clk);
		u_twowire_master_model.start();
		for (int i = 0; i < 4; i++)
			u_twowire_master_model.clk_bit(i != 1, ack);
		u_twowire_master_model.recover();
		probe({DEVICE_TYPE, pins, 1'b0}, 1);
		rnd = lfsr(rnd);
		hi = rnd;
		wr_txn(hi, 8'hff, dt);
		report("busy standby", 0, standby);
		axi_rd(POINTER_OFFSET, d, r);
		report("page wrap pointer", {16'h0, hi, 8'h80}, d);
		axi_rd(LAST_BYTE_OFFSET, d, r);
		report("last byte", {16'h0, 8'h01, dt}, d);
		probe({DEVICE_TYPE, pins, 1'b0}, 0);
		repeat (WCYC) @(posedge core_clk);
		report("standby after write", 1, standby);
		write_protect <= 1'b1;
		wr_txn(hi, 8'h00, dt);
		report("protected standby", 1, standby);
		write_protect <= 1'b0;
		axi_wr(CTRL_OFFSET, 32'h0, r);
		probe({DEVICE_TYPE, pins, 1'b0}, 0);
		axi_wr(CTRL_OFFSET, 32'h1, r);
		probe({DEVICE_TYPE, pins, 1'b0}, 1);
		conclude();
	end
endmodule
